// [dcgps_pkg.sv]
// package for the device clock gating and power state block
package dcgps_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [15:0] DCGPS_GATE_OFFSET = 16'h0404;
	localparam logic [31:0] DCGPS_GATE_RESET = 32'h00000000;
	// writable bits: 14..7, 4, 3
	localparam logic [31:0] DCGPS_GATE_WMASK = 32'h00007F98;

	// ****************************************
	// gate bit positions
	// ****************************************
	localparam int DCGPS_BIT_TIMER = 14;
	localparam int DCGPS_BIT_RAM = 13;
	localparam int DCGPS_BIT_MEDIA = 12;
	localparam int DCGPS_BIT_CIPHER = 11;
	localparam int DCGPS_BIT_SPI = 10;
	localparam int DCGPS_BIT_CARD = 9;
	localparam int DCGPS_BIT_UART = 8;
	localparam int DCGPS_BIT_USB = 7;
	localparam int DCGPS_BIT_SD2 = 4;
	localparam int DCGPS_BIT_SD1 = 3;
	localparam int DCGPS_NUM_UNITS = 10;

	// ****************************************
	// timing
	// ****************************************
	localparam int DCGPS_CLK_MHZ = 20;
	localparam int DCGPS_CORE_RST_NS = 200;
	localparam int DCGPS_CORE_RST_CYC = (DCGPS_CORE_RST_NS * DCGPS_CLK_MHZ + 999) / 1000;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		DCGPS_STATE_FULL_ACTIVE,
		DCGPS_STATE_GATED_FAST,
		DCGPS_STATE_GATED_SLOW,
		DCGPS_STATE_SUSPENDED
	} dcgps_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [31:0] wdata;
	} dcgps_req_t;

	typedef struct packed {
		logic pll_en;
		logic ring_osc_enable;
	} dcgps_osc_t;

endpackage

// [dcgps_gate_cell.sv]
// one gated unit: clock enable and interface enable
`timescale 1ns/10ps
module dcgps_gate_cell
	import dcgps_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// control
	input wire logic gate_on,
	input wire logic bus_sleep,
	// outputs
	output logic clk_en_q,
	output logic ifc_en_q
);

	// the clock enable also drops while the bus sleeps, the interface does not
	always_ff @(posedge clk) begin
		if (rst) begin
			clk_en_q <= 1'b0;
			ifc_en_q <= 1'b0;
		end else if (ce) begin
			clk_en_q <= gate_on & ~bus_sleep;
			ifc_en_q <= gate_on;
		end
	end

endmodule

// [dcgps_core_reset.sv]
// one-shot reset pulse to the usb device core on first gate enable
`timescale 1ns/10ps
module dcgps_core_reset
	import dcgps_pkg::*;
#(
	parameter int PULSE_CYC = DCGPS_CORE_RST_CYC
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// trigger
	input wire logic usb_gate,
	// pulse
	output logic core_rst_q
);

	logic armed_q;
	logic [7:0] cnt_q;
	wire logic fire = armed_q & usb_gate;

	// armed only until the first enable, so later toggles do not reset the core
	always_ff @(posedge clk) begin
		if (rst) begin
			armed_q <= 1'b1;
			cnt_q <= 8'h00;
			core_rst_q <= 1'b0;
		end else if (ce) begin
			if (fire) begin
				armed_q <= 1'b0;
				cnt_q <= 8'(PULSE_CYC);
				core_rst_q <= 1'b1;
			end else if (cnt_q > 8'h01) begin
				cnt_q <= cnt_q - 8'h01;
			end else begin
				cnt_q <= 8'h00;
				core_rst_q <= 1'b0;
			end
		end
	end

	core_pulse_a: assert property (
		@(posedge clk) disable iff (rst) ce && fire |=> core_rst_q)
		else $error("core reset did not follow first usb enable");

endmodule

// [dcgps_top.sv]
// clock gate register and power state manager
`timescale 1ns/10ps

// Operation
// - bit 14 passes the timer clock when set
// - bit 13 passes the bus ram clock when set
// - bit 12 clocks the media data unit; clear shuts its logic
// - bit 11 clear stops cipher logic but keeps cipher ram enabled
// - bit 10 clear stops spi clock, logic and interface
// - bit 9 clear stops smart card clock, logic and interface
// - bit 8 clear stops uart clock, logic and interface
// - bit 7 clear stops usb engine clocks and its phy
// - usb gate clear: resume neither wakes engine nor starts pll
// - first usb gate set after reset resets the usb device core
// - bits 4 and 3 gate second and first sd controllers
// - outside state zero, a zero gate bit puts its unit in low power
// - always exactly one of four power states
// - state zero: pll on, all clocks but usb ungated; reset or firmware enters
// - state one: pll on, firmware or wake entry, firmware only exit
// - states one and two gate unused clocks, stop bus clock on sleep
// - state two: pll off, ring osc on, no usb, firmware entry
// - wake in state two restarts pll and enters state one
// - wake in states zero and one leaves the state unchanged
// - state three: both oscillators off; only wake or reset exits
// - wake in state three enters state one
// - reset enters state zero from any state
// - any wake sets the ring oscillator enable
module dcgps_top
	import dcgps_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// register port
	input wire dcgps_req_t req,
	output logic [31:0] rdata_q,
	// firmware oscillator control and events
	input wire dcgps_osc_t osc_wr,
	input wire logic osc_wr_stb,
	input wire logic wake_usb,
	input wire logic wake_other,
	input wire logic cpu_sleep,
	// unit clock enables, order 14..7,4,3 packed
	output logic [DCGPS_NUM_UNITS-1:0] unit_clk_en_q,
	output logic [DCGPS_NUM_UNITS-1:0] unit_ifc_en_q,
	output logic cipher_ram_en_q,
	output logic usb_phy_on_q,
	output logic core_rst_q,
	// oscillators and state
	output logic pll_en_q,
	output logic ring_osc_enable_q,
	output dcgps_state_t state_q,
	output logic bus_clk_en_q
);

	// ****************************************
	// register decode
	// ****************************************
	logic [31:0] gate_q;
	wire logic hit = req.addr == DCGPS_GATE_OFFSET;
	wire logic gate_wr = req.wr & hit;
	wire logic [31:0] gate_d = req.wdata & DCGPS_GATE_WMASK;
	wire logic usb_gate = gate_q[DCGPS_BIT_USB];
	// usb resume is ignored while the engine is gated off
	wire logic usb_wake = wake_usb & usb_gate;
	wire logic any_wake = usb_wake | wake_other;
	wire logic sleep_gate = cpu_sleep & ((state_q == DCGPS_STATE_GATED_FAST)
		| (state_q == DCGPS_STATE_GATED_SLOW));

	// gate register; reserved bits stay zero through the mask
	always_ff @(posedge clk) begin
		if (rst) begin
			gate_q <= DCGPS_GATE_RESET;
		end else if (ce && gate_wr) begin
			gate_q <= gate_d;
		end
	end

	// read data: unmapped addresses read zero
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= 32'h00000000;
		end else if (ce && req.rd) begin
			rdata_q <= hit ? gate_q : 32'h00000000;
		end
	end

	// ****************************************
	// per unit gating
	// ****************************************
	localparam int UNIT_BIT [DCGPS_NUM_UNITS] = '{DCGPS_BIT_SD1, DCGPS_BIT_SD2, DCGPS_BIT_USB,
		DCGPS_BIT_UART, DCGPS_BIT_CARD, DCGPS_BIT_SPI, DCGPS_BIT_CIPHER, DCGPS_BIT_MEDIA,
		DCGPS_BIT_RAM, DCGPS_BIT_TIMER};

	// state zero forces every clock but usb on regardless of the gate bits
	wire logic all_on = state_q == DCGPS_STATE_FULL_ACTIVE;

	genvar g;
	generate
		for (g = 0; g < DCGPS_NUM_UNITS; g++) begin : g_unit
			// one cell per gate bit
			dcgps_gate_cell u_cell (
				.clk(clk),
				.rst(rst),
				.ce(ce),
				.gate_on(gate_q[UNIT_BIT[g]] | (all_on & (UNIT_BIT[g] != DCGPS_BIT_USB))),
				.bus_sleep(sleep_gate),
				.clk_en_q(unit_clk_en_q[g]),
				.ifc_en_q(unit_ifc_en_q[g])
			);
		end
	endgenerate

	// cipher ram is never gated by its control bit; phy follows the usb gate
	always_ff @(posedge clk) begin
		if (rst) begin
			cipher_ram_en_q <= 1'b1;
			usb_phy_on_q <= 1'b0;
			bus_clk_en_q <= 1'b1;
		end else if (ce) begin
			cipher_ram_en_q <= 1'b1;
			usb_phy_on_q <= usb_gate;
			bus_clk_en_q <= ~sleep_gate;
		end
	end

	// core reset pulse on first usb enable
	dcgps_core_reset u_core_rst (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.usb_gate(usb_gate),
		.core_rst_q(core_rst_q)
	);

	// ****************************************
	// oscillator enables
	// ****************************************
	// wake sets ring osc and wins over a firmware clear in the same cycle
	logic rosc_d;
	logic pll_d;
	assign rosc_d = any_wake | (osc_wr_stb ? osc_wr.ring_osc_enable : ring_osc_enable_q);
	// pll restarts on usb wake or any wake out of the slow or suspended state
	assign pll_d = usb_wake | (any_wake & (state_q == DCGPS_STATE_GATED_SLOW))
		| (any_wake & (state_q == DCGPS_STATE_SUSPENDED))
		| (osc_wr_stb ? osc_wr.pll_en : pll_en_q);

	always_ff @(posedge clk) begin
		if (rst) begin
			ring_osc_enable_q <= 1'b1;
			pll_en_q <= 1'b1;
		end else if (ce) begin
			ring_osc_enable_q <= rosc_d;
			pll_en_q <= pll_d;
		end
	end

	// ****************************************
	// power state
	// ****************************************
	// firmware writes choose the state; wakes move slow states to one
	dcgps_state_t state_d;
	always_comb begin
		state_d = state_q;
		case (state_q)
			DCGPS_STATE_FULL_ACTIVE, DCGPS_STATE_GATED_FAST: begin
				// wake leaves these states alone
				if (osc_wr_stb) begin
					if (!osc_wr.pll_en)
						state_d = osc_wr.ring_osc_enable ? DCGPS_STATE_GATED_SLOW
							: DCGPS_STATE_SUSPENDED;
					else if (gate_wr)
						state_d = DCGPS_STATE_GATED_FAST;
				end else if (gate_wr) begin
					state_d = (gate_d == DCGPS_GATE_WMASK) ? DCGPS_STATE_FULL_ACTIVE
						: DCGPS_STATE_GATED_FAST;
				end
			end
			DCGPS_STATE_GATED_SLOW: begin
				if (any_wake)
					state_d = DCGPS_STATE_GATED_FAST;
				else if (osc_wr_stb && osc_wr.pll_en)
					state_d = DCGPS_STATE_GATED_FAST;
				else if (osc_wr_stb && !osc_wr.ring_osc_enable)
					state_d = DCGPS_STATE_SUSPENDED;
			end
			DCGPS_STATE_SUSPENDED: begin
				if (any_wake)
					state_d = DCGPS_STATE_GATED_FAST;
			end
			default: state_d = DCGPS_STATE_FULL_ACTIVE;
		endcase
	end

	// reset always lands in state zero
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= DCGPS_STATE_FULL_ACTIVE;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	timer_gate_a: assert property (ce && gate_wr |=> gate_q[DCGPS_BIT_TIMER] == $past(req.wdata[14]))
		else $error("timer gate bit not stored");
	ram_gate_a: assert property (ce && gate_wr |=> gate_q[DCGPS_BIT_RAM] == $past(req.wdata[13]))
		else $error("ram gate bit not stored");
	cipher_ram_a: assert property (cipher_ram_en_q)
		else $error("cipher ram disabled");
	phy_follow_a: assert property (ce |=> usb_phy_on_q == $past(usb_gate))
		else $error("phy does not follow usb gate");
	usb_block_a: assert property (
		ce && wake_usb && !usb_gate && !wake_other && !osc_wr_stb && !pll_en_q
		&& state_q inside {DCGPS_STATE_GATED_SLOW, DCGPS_STATE_SUSPENDED} |=> !pll_en_q)
		else $error("gated usb resume started pll");
	rosc_wake_a: assert property (ce && any_wake |=> ring_osc_enable_q)
		else $error("wake did not set ring osc");
	slow_wake_a: assert property (
		ce && any_wake && state_q == DCGPS_STATE_GATED_SLOW
		|=> state_q == DCGPS_STATE_GATED_FAST && pll_en_q)
		else $error("wake in slow state did not reach state one");
	susp_wake_a: assert property (
		ce && any_wake && state_q == DCGPS_STATE_SUSPENDED |=> state_q == DCGPS_STATE_GATED_FAST)
		else $error("wake in suspend did not reach state one");
	fast_hold_a: assert property (
		ce && any_wake && !osc_wr_stb && !gate_wr
		&& state_q inside {DCGPS_STATE_FULL_ACTIVE, DCGPS_STATE_GATED_FAST} |=> $stable(state_q))
		else $error("wake changed a fast state");
	// reset itself is the antecedent, so the default disable must not apply here
	reset_state_a: assert property (
		@(posedge clk) disable iff (1'b0) rst |=> state_q == DCGPS_STATE_FULL_ACTIVE)
		else $error("reset did not reach state zero");

	slow_c: cover property (state_q == DCGPS_STATE_GATED_SLOW
		##1 state_q == DCGPS_STATE_GATED_FAST);
	susp_c: cover property (state_q == DCGPS_STATE_SUSPENDED
		##1 state_q == DCGPS_STATE_GATED_FAST);
	core_c: cover property (core_rst_q);

endmodule

// [dcgps_tb.sv]
// self-checking testbench for the clock gate register and power state manager
`timescale 1ns/10ps
`define CHK(g, e) chk_val(32'(g), 32'(e))
module testbench
	import dcgps_pkg::*;
;
	// ****************************************
	// stimulus and observed ports
	// ****************************************
	logic clk = 1'b0;
	logic rst = 1'b1;
	dcgps_req_t req = '0;
	dcgps_osc_t osc_wr = '0;
	logic osc_wr_stb = 1'b0;
	logic wake_usb = 1'b0;
	logic wake_other = 1'b0;
	logic cpu_sleep = 1'b0;
	logic [31:0] rdata_q;
	logic [9:0] clk_en;
	logic [9:0] ifc_en;
	logic ram_en, phy_on, core_rst, pll_en, ring_osc_on, bus_en;
	logic ce = 1'b1;
	dcgps_state_t st;
	logic [31:0] rd_v;
	int n_mismatch = 0;
	int cmp_count = 0;

	// ce dropped once to check that a frozen block ignores writes
	dcgps_top i_dut (.clk(clk), .rst(rst), .ce(ce), .req(req), .rdata_q(rdata_q),
		.osc_wr(osc_wr), .osc_wr_stb(osc_wr_stb), .wake_usb(wake_usb),
		.wake_other(wake_other), .cpu_sleep(cpu_sleep), .unit_clk_en_q(clk_en),
		.unit_ifc_en_q(ifc_en), .cipher_ram_en_q(ram_en), .usb_phy_on_q(phy_on),
		.core_rst_q(core_rst), .pll_en_q(pll_en), .ring_osc_enable_q(ring_osc_on), .state_q(st),
		.bus_clk_en_q(bus_en));

	// 20 MHz clock
	always #25 clk = ~clk;

	// ****************************************
	// helpers
	// ****************************************
	task automatic tick();
		@(posedge clk);
		#5;
	endtask

	task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// write lands at the first edge; unit enables lag one more edge
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		tick();
		req.wr = 1'b0;
		tick();
	endtask

	task automatic rd(input logic [15:0] a);
		req.rd = 1'b1;
		req.addr = a;
		tick();
		req.rd = 1'b0;
		rd_v = rdata_q;
	endtask

	task automatic osc(input logic p, input logic r);
		osc_wr = '{pll_en: p, ring_osc_enable: r};
		osc_wr_stb = 1'b1;
		tick();
		osc_wr_stb = 1'b0;
		tick();
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		rd(DCGPS_GATE_OFFSET);
		`CHK(rd_v, DCGPS_GATE_RESET);
		`CHK(st, DCGPS_STATE_FULL_ACTIVE);
		`CHK({pll_en, ring_osc_on, ram_en, phy_on, core_rst, bus_en}, 6'h39);
		`CHK(clk_en, 10'h3FB);
		rd(16'h0408);
		`CHK(rd_v, 32'h00000000);
		$display("test reset done");
	endtask

	// the core reset pulse is counted over a fixed window
	task automatic t_usb();
		int n;
		n = 0;
		req.wr = 1'b1;
		req.addr = DCGPS_GATE_OFFSET;
		req.wdata = 32'h00000080;
		tick();
		req.wr = 1'b0;
		`CHK(st, DCGPS_STATE_GATED_FAST);
		for (int i = 0; i < 12; i++) begin
			tick();
			n += core_rst;
		end
		`CHK(n, DCGPS_CORE_RST_CYC);
		`CHK(phy_on, 1'b1);
		wr(DCGPS_GATE_OFFSET, 32'h00000000);
		tick();
		`CHK(phy_on, 1'b0);
		n = 0;
		wr(DCGPS_GATE_OFFSET, 32'h00000080);
		for (int i = 0; i < 10; i++) begin
			tick();
			n += core_rst;
		end
		`CHK(n, 0);
		$display("test usb done");
	endtask

	// each gate bit alone lights only its own unit
	task automatic t_bits();
		int bits[10] = '{3, 4, 7, 8, 9, 10, 11, 12, 13, 14};
		for (int i = 0; i < 10; i++) begin
			wr(DCGPS_GATE_OFFSET, 32'h1 << bits[i]);
			`CHK({clk_en, ifc_en}, {10'h1 << i, 10'h1 << i});
			`CHK(st, DCGPS_STATE_GATED_FAST);
			`CHK(ram_en, 1'b1);
		end
		wr(DCGPS_GATE_OFFSET, 32'hFFFFFFFF);
		rd(DCGPS_GATE_OFFSET);
		`CHK(rd_v, DCGPS_GATE_WMASK);
		`CHK(st, DCGPS_STATE_FULL_ACTIVE);
		`CHK(clk_en, 10'h3FF);
		wr(DCGPS_GATE_OFFSET, 32'h00004000);
		`CHK(clk_en, 10'h200);
		// with ce low the write must not land
		ce = 1'b0;
		wr(DCGPS_GATE_OFFSET, 32'h00000008);
		`CHK(clk_en, 10'h200);
		ce = 1'b1;
		rd(DCGPS_GATE_OFFSET);
		`CHK(rd_v, 32'h00004000);
		$display("test bits done");
	endtask

	task automatic t_power();
		osc(1'b0, 1'b1);
		`CHK({st, pll_en, ring_osc_on}, {DCGPS_STATE_GATED_SLOW, 2'b01});
		wake_usb = 1'b1;
		tick();
		wake_usb = 1'b0;
		tick();
		`CHK({st, pll_en}, {DCGPS_STATE_GATED_SLOW, 1'b0});
		for (int i = 0; i < 2; i++) begin
			wake_other = 1'b1;
			tick();
			wake_other = 1'b0;
			tick();
			`CHK({st, pll_en}, {DCGPS_STATE_GATED_FAST, 1'b1});
		end
		cpu_sleep = 1'b1;
		tick();
		tick();
		`CHK({bus_en, ifc_en, clk_en}, {1'b0, 10'h200, 10'h000});
		cpu_sleep = 1'b0;
		osc(1'b0, 1'b0);
		`CHK({st, pll_en, ring_osc_on}, {DCGPS_STATE_SUSPENDED, 2'b00});
		wake_other = 1'b1;
		tick();
		wake_other = 1'b0;
		tick();
		`CHK({st, ring_osc_on}, {DCGPS_STATE_GATED_FAST, 1'b1});
		osc(1'b0, 1'b0);
		rst = 1'b1;
		tick();
		rst = 1'b0;
		rd(DCGPS_GATE_OFFSET);
		`CHK({rd_v, st}, {32'h0, DCGPS_STATE_FULL_ACTIVE});
		$display("test power done");
	endtask

	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial begin
		repeat (6) @(posedge clk);
		#5;
		rst = 1'b0;
		t_reset();
		t_usb();
		t_bits();
		t_power();
		tally_and_finish();
	end

	// a hang counts as a mismatch
	initial begin
		#250000;
		n_mismatch++;
		tally_and_finish();
	end
endmodule
